// ==== hdl/mst_timer.sv ====
// Step timer with auto-updated step ratio, simulated events and debug pins.
// Assumes event inputs come from logic on mclk, one cycle pulses.
//
// Operation
// - Autoswitched overflow: ratio up, halve timer and scaled registers, set increment flag.
// - After auto increment timer resumes at 80h; overflow flag set when the CA_TES bits are zero.
// - Zero-cross with timer below 55h: ratio down, double registers, set decrement flag.
// - Ratio zero is never decremented and raises no decrement flag.
// - At ratio 15 overflow restarts at zero, no scaling, no increment flag.
// - While saturated, detection and events keep working.
// - Scaled registers: timer, capture, previous capture, commutation and demag compare.
// - Debug enable puts commutation, demag and zero events on the two debug pins.
// - Commutation right after zero-cross still shows a glitch on the zero pin.
// - Speed mode: demag pin toggles on capture, zero pin on update.
// - Sensor mode: demag pin toggles on commutation, zero pin shows zero-cross.
// - Demag compare overflowing the range ends as median plus half the excess.
// - Per-step bits preload, applied at commutation or phase write in direct mode.
// - Timer and ratio writable only before clock enable; then ratio only steps.
// - Enabled simulated events fire when the timer reaches the compare value.
// - Compare at or below timer fires at once and is overwritten by the timer.
// - Hardware commutation needs commutation, then demag, then zero-cross.
// - Simulated commutation ignores the multiplier and allows consecutive commutations.
// - In simulated commutation autoswitched zero-cross still resets timer; demag then zero holds.
// - After simulated commutation enable, compare stays off until a compare write.
// - With autoswitch on, hardware zero-cross captures timer, shifts old capture to previous, resets timer.
// - Commutation compare is weight times selected capture divided by 256.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module mst_timer (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Position events
	input wire logic hw_demag_in,
	input wire logic hw_zero_in,
	input wire logic speed_capture_in,
	input wire logic speed_update_in,
	// Event and status outputs
	output logic commutation_evt,
	output logic demag_evt,
	output logic zero_evt,
	output logic ratio_irq,
	output mst_pkg::mst_step_cfg_t step_cfg,
	output logic zero_event_debug_pin,
	output logic demag_event_debug_pin
);
	mst_pkg::mst_state_t s;
	mst_pkg::mst_state_t n;
	logic [7:0] next_rdata;
	logic run, as, tes0, tick, ovf, c_evt, d_evt, z_evt, z_sim, d_sim;
	logic inc_ok, dec_ok, sh_dn;
	logic [15:0] lim, prod;

	////////////////////////////////////////////////////////////////////////
	// Event detection
	always_comb begin
		run = s.ca[mst_pkg::CA_CKE];
		as = s.ca[mst_pkg::CA_SWA];
		tes0 = s.ca[mst_pkg::CA_TES +: 2] == 2'h0;
		lim = (16'h1 << s.ratio) - 16'h1;
		tick = run && s.pcnt == lim;
		ovf = tick && s.timer == mst_pkg::TOP;
		inc_ok = as && s.ratio != mst_pkg::RATIO_MAX;
		c_evt = run && s.c_armed && s.comp <= s.timer && (s.sc || s.seq == mst_pkg::SEQ_C);
		d_sim = s.cfg.cb[mst_pkg::CB_SDM] && s.d_armed && s.dem <= s.timer;
		d_evt = run && (s.seq == mst_pkg::SEQ_D || (s.sc && s.seq == mst_pkg::SEQ_C))
			&& ((s.cfg.cb[mst_pkg::CB_HDM] && hw_demag_in) || d_sim);
		z_sim = s.sz && s.z_armed && s.zcap <= s.timer;
		z_evt = run && s.seq == mst_pkg::SEQ_Z && (hw_zero_in || z_sim);
		dec_ok = as && z_evt && s.timer < mst_pkg::DEC_LIMIT && s.ratio != 4'h0;
		prod = 16'(s.weight) * 16'(s.ca[mst_pkg::CA_DCB] ? s.zcap : s.prev);
		sh_dn = ovf && inc_ok && !z_evt;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = s;
		n.sc_prev = s.sc;
		n.mul_req = 1'b0;
		if (run) begin
			n.pcnt = tick ? 16'h0 : s.pcnt + 16'h1;
		end
		if (tick) begin
			n.timer = s.timer + 8'h1;
		end
		// Overflow: scale down one ratio step, or restart when saturated or autoswitch is off
		// Zero-cross in the same cycle wins, so no half-scaled state
		if (ovf && !z_evt) begin
			if (inc_ok) begin
				n.ratio = s.ratio + 4'h1;
				n.timer = mst_pkg::MEDIAN;
				n.comp = {1'b0, s.comp[7:1]};
				n.zcap = {1'b0, s.zcap[7:1]};
				n.prev = {1'b0, s.prev[7:1]};
				n.dem = {1'b0, s.dem[7:1]} + mst_pkg::MEDIAN;
				n.mul_req = s.seq == mst_pkg::SEQ_C && !s.sc;
			end else begin
				n.timer = 8'h0;
			end
		end
		// Commutation: compare overwritten by timer, step config applied unless in direct mode
		if (c_evt) begin
			n.comp = s.timer;
			n.c_armed = 1'b0;
			if (!(s.sc && s.seq == mst_pkg::SEQ_Z)) begin
				n.seq = mst_pkg::SEQ_D;
			end
			if (!s.ca[mst_pkg::CA_DIR]) begin
				n.cfg = s.shadow;
			end
			if (!as) begin
				n.timer = 8'h0;
			end
		end
		if (d_evt) begin
			if (d_sim) begin
				n.dem = s.timer;
			end
			n.d_armed = 1'b0;
			n.seq = mst_pkg::SEQ_Z;
		end
		// Zero-cross: capture, shift, reset timer, maybe scale up
		if (z_evt) begin
			n.z_armed = 1'b0;
			n.seq = mst_pkg::SEQ_C;
			if (as) begin
				n.zcap = s.timer;
				n.prev = z_sim ? s.timer : s.zcap;
				n.timer = 8'h0;
				n.pcnt = 16'h0;
				n.mul_req = !s.sc;
				if (dec_ok) begin
					n.ratio = s.ratio - 4'h1;
					n.zcap = {s.timer[6:0], 1'b0};
					n.prev = z_sim ? {s.timer[6:0], 1'b0} : {s.zcap[6:0], 1'b0};
					n.comp = {n.comp[6:0], 1'b0};
					n.dem = {s.dem[6:0], 1'b0};
				end
			end
		end
		// Multiplier result loads the hardware compare
		if (s.mul_req && !s.sc && as) begin
			n.comp = prod[15:8];
			n.c_armed = 1'b1;
		end
		if (s.sc && !s.sc_prev) begin
			n.c_armed = 1'b0;
		end
		// Register writes
		if (wr) begin
			unique case (addr)
				mst_pkg::A_TIMER: begin
					if (!run) begin
						n.timer = wdata;
					end
				end
				mst_pkg::A_COMP: begin
					n.comp = wdata;
					n.c_armed = 1'b1;
				end
				mst_pkg::A_ZCAP: begin
					n.zcap = wdata;
					n.z_armed = 1'b1;
				end
				mst_pkg::A_PREV: n.prev = wdata;
				mst_pkg::A_DEMAG: begin
					n.dem = wdata;
					n.d_armed = 1'b1;
				end
				mst_pkg::A_PRESC: begin
					if (!run) begin
						n.ratio = wdata[3:0];
					end
				end
				mst_pkg::A_STATUS: begin
					n.inc = s.inc && wdata[mst_pkg::S_INC];
					n.dec = s.dec && wdata[mst_pkg::S_DEC];
				end
				mst_pkg::A_CTRL_A: begin
					n.ca = wdata;
					n.mul_req = !run && wdata[mst_pkg::CA_CKE] && wdata[mst_pkg::CA_SWA];
				end
				mst_pkg::A_CTRL_B: n.shadow.cb = wdata[3:0];
				mst_pkg::A_CTRL_C: begin
					n.sc = wdata[mst_pkg::CC_SC];
					n.sz = wdata[mst_pkg::CC_SZ];
					n.ovf = s.ovf && wdata[mst_pkg::CC_OVF];
					n.dbg = wdata[mst_pkg::CC_DBG];
				end
				mst_pkg::A_PHASE: begin
					n.shadow.ph = wdata;
					if (s.ca[mst_pkg::CA_DIR]) begin
						n.cfg = {s.shadow.cb, wdata};
					end
				end
				mst_pkg::A_WEIGHT: n.weight = wdata;
				default: ;
			endcase
		end
		// Hardware sets win over software clears
		if (sh_dn) begin
			n.inc = 1'b1;
		end
		if (dec_ok) begin
			n.dec = 1'b1;
		end
		if (ovf && tes0 && !z_evt) begin
			n.ovf = 1'b1;
		end
		// Debug pins
		n.dpin = 1'b0;
		n.zpin = 1'b0;
		if (s.dbg) begin
			if (!tes0) begin
				n.dpin = s.dpin ^ speed_capture_in;
				n.zpin = s.zpin ^ speed_update_in;
			end else if (s.ca[mst_pkg::CA_SENS]) begin
				n.dpin = s.dpin ^ c_evt;
				n.zpin = z_evt;
			end else begin
				n.dpin = d_evt;
				n.zpin = z_evt || (c_evt && s.zpin);
			end
		end
	end

	always_comb begin
		next_rdata = 8'h0;
		if (rd) begin
			unique case (addr)
				mst_pkg::A_TIMER: next_rdata = s.timer;
				mst_pkg::A_COMP: next_rdata = s.comp;
				mst_pkg::A_ZCAP: next_rdata = s.zcap;
				mst_pkg::A_PREV: next_rdata = s.prev;
				mst_pkg::A_DEMAG: next_rdata = s.dem;
				mst_pkg::A_PRESC: next_rdata = {4'h0, s.ratio};
				mst_pkg::A_STATUS: next_rdata = {6'h0, s.dec, s.inc};
				mst_pkg::A_CTRL_A: next_rdata = s.ca;
				mst_pkg::A_CTRL_B: next_rdata = {4'h0, s.shadow.cb};
				mst_pkg::A_CTRL_C: next_rdata = {4'h0, s.dbg, s.ovf, s.sz, s.sc};
				mst_pkg::A_PHASE: next_rdata = s.shadow.ph;
				mst_pkg::A_WEIGHT: next_rdata = s.weight;
				default: next_rdata = 8'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= mst_pkg::ST_RESET;
			rdata <= 8'h0;
		end else if (ce) begin
			s <= n;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign commutation_evt = c_evt && ce;
	assign demag_evt = d_evt && ce;
	assign zero_evt = z_evt && ce;
	assign ratio_irq = s.ca[mst_pkg::CA_MASK] && (s.inc || s.dec);
	assign step_cfg = s.cfg;
	assign zero_event_debug_pin = s.zpin;
	assign demag_event_debug_pin = s.dpin;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb_chk @(posedge mclk); endclocking
	default disable iff (rst);

	a_ovf_scales: assert property (ce && sh_dn && !wr |=> s.timer == 8'h80
		&& s.ratio == $past(s.ratio) + 4'h1 && s.inc)
		else $error("overflow did not step ratio up");
	a_ovf_flag: assert property (ce && ovf && tes0 && !z_evt |=> s.ovf)
		else $error("overflow flag not set");
	a_zero_scales: assert property (ce && dec_ok && !wr |=> s.ratio == $past(s.ratio) - 4'h1
		&& s.dec && s.zcap == {$past(s.timer[6:0]), 1'b0})
		else $error("zero-cross did not step ratio down");
	a_ratio_floor: assert property (ce && z_evt && s.ratio == 4'h0 && !s.dec |=> !s.dec)
		else $error("decrement at ratio zero");
	a_sat_hold: assert property (ce && ovf && s.ratio == 4'hf && !z_evt && !wr
		|=> s.ratio == 4'hf && s.timer == 8'h0 && s.inc == $past(s.inc))
		else $error("saturated overflow misbehaved");
	a_ratio_lock: assert property (ce && run && !ovf && !z_evt |=> s.ratio == $past(s.ratio))
		else $error("ratio changed while running");
	a_cmp_overwrite: assert property (ce && c_evt && !(wr && addr == mst_pkg::A_COMP)
		&& !s.mul_req |=> s.comp == $past(s.timer) && !s.c_armed)
		else $error("compare not overwritten by timer");
	a_evt_order: assert property (d_evt |-> s.seq == mst_pkg::SEQ_D || s.sc)
		else $error("demag out of order");
	a_zero_capture: assert property (ce && z_evt && as && !dec_ok && !z_sim && !wr
		|=> s.zcap == $past(s.timer) && s.prev == $past(s.zcap) && s.timer == 8'h0)
		else $error("zero-cross capture wrong");
	a_sc_disarm: assert property (ce && s.sc && !s.sc_prev && !wr |=> !s.c_armed)
		else $error("compare armed after enable");
	a_dbg_quiet: assert property (ce && !s.dbg |=> !zero_event_debug_pin && !demag_event_debug_pin)
		else $error("debug pins active while off");
endmodule // mst_timer
`default_nettype wire

// ==== hdl/mst_pkg.sv ====
// Step timer package: register offsets, field positions, constants, types.
// Assumes an 8-bit register port and one clock domain.
package mst_pkg;
	// Register offsets
	localparam logic [3:0] A_TIMER = 4'h0;
	localparam logic [3:0] A_COMP = 4'h1;
	localparam logic [3:0] A_ZCAP = 4'h2;
	localparam logic [3:0] A_PREV = 4'h3;
	localparam logic [3:0] A_DEMAG = 4'h4;
	localparam logic [3:0] A_PRESC = 4'h5;
	localparam logic [3:0] A_STATUS = 4'h6;
	localparam logic [3:0] A_CTRL_A = 4'h7;
	localparam logic [3:0] A_CTRL_B = 4'h8;
	localparam logic [3:0] A_CTRL_C = 4'h9;
	localparam logic [3:0] A_PHASE = 4'ha;
	localparam logic [3:0] A_WEIGHT = 4'hb;
	// Field positions
	localparam int S_INC = 0;
	localparam int S_DEC = 1;
	localparam int CA_CKE = 0;
	localparam int CA_SWA = 1;
	localparam int CA_DCB = 2;
	localparam int CA_MASK = 3;
	localparam int CA_TES = 4;
	localparam int CA_DIR = 6;
	localparam int CA_SENS = 7;
	localparam int CB_HDM = 1;
	localparam int CB_SDM = 2;
	localparam int CC_SC = 0;
	localparam int CC_SZ = 1;
	localparam int CC_OVF = 2;
	localparam int CC_DBG = 3;
	// Timer constants
	localparam logic [7:0] MEDIAN = 8'h80;
	localparam logic [7:0] DEC_LIMIT = 8'h55;
	localparam logic [7:0] TOP = 8'hff;
	localparam logic [3:0] RATIO_MAX = 4'hf;

	typedef enum logic [1:0] {
		SEQ_C = 2'b00,
		SEQ_D = 2'b01,
		SEQ_Z = 2'b10
	} mst_seq_t;

	// Per-step configuration: control_b bits and phase state
	typedef struct packed {
		logic [3:0] cb;
		logic [7:0] ph;
	} mst_step_cfg_t;

	typedef struct packed {
		logic [15:0] pcnt;
		logic [7:0] timer;
		logic [3:0] ratio;
		logic [7:0] comp;
		logic [7:0] zcap;
		logic [7:0] prev;
		logic [7:0] dem;
		logic [7:0] weight;
		logic inc;
		logic dec;
		logic ovf;
		logic [7:0] ca;
		logic sc;
		logic sz;
		logic dbg;
		logic sc_prev;
		mst_step_cfg_t shadow;
		mst_step_cfg_t cfg;
		logic c_armed;
		logic d_armed;
		logic z_armed;
		logic mul_req;
		mst_seq_t seq;
		logic dpin;
		logic zpin;
	} mst_state_t;

	localparam mst_state_t ST_RESET = '0;
endpackage

// ==== tb/mst_timer_tb.sv ====
// Self-checking bench for the step timer: register port, events, debug pins.
// Assumes rdata is valid only in the cycle after a read strobe.
`timescale 1ns/100ps
`default_nettype none
module mst_timer_tb;
	logic mclk, rst, ce, wr, rd, hdem, hzero, scap, supd;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v, r1, r2;
	logic c_evt, d_evt, z_evt, irq, zpin, dpin, z0, d0;
	mst_pkg::mst_step_cfg_t cfg;
	int mismatches = 0, num_checks = 0, cycles = 0, ncomm = 0, expc = 0, nc, nu, ndem = 0, nzero = 0;

	mst_timer dut_u (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .hw_demag_in(hdem), .hw_zero_in(hzero), .speed_capture_in(scap),
		.speed_update_in(supd), .commutation_evt(c_evt), .demag_evt(d_evt), .zero_evt(z_evt),
		.ratio_irq(irq), .step_cfg(cfg), .zero_event_debug_pin(zpin), .demag_event_debug_pin(dpin));

	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Hang guard: saturated overflow alone needs about 33k cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (c_evt === 1'b1) ncomm <= ncomm + 1;
		if (d_evt === 1'b1) ndem <= ndem + 1;
		if (z_evt === 1'b1) nzero <= nzero + 1;
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////
	task check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task close_out;
		if (mismatches == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task rd_reg(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task pulse(input int k);
		@(posedge mclk);
		if (k == 0) hdem <= 1'b1;
		else hzero <= 1'b1;
		@(posedge mclk);
		hdem <= 1'b0;
		hzero <= 1'b0;
		#1;
	endtask

	task poll_ovf;
		for (int k = 0; k < 20000; k++) begin
			rd_reg(mst_pkg::A_CTRL_C);
			if (v[2] === 1'b1) break;
		end
	endtask

	// Forced commutation, hardware demag, then hardware zero-cross
	task step(input logic [3:0] ratio_exp, input logic [7:0] st_exp);
		wr_reg(mst_pkg::A_COMP, 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		expc++;
		check(8'(ncomm), 8'(expc));
		check({4'h0, cfg.cb}, 8'h02);
		check(cfg.ph, 8'h3c);
		pulse(0);
		check({7'h0, dpin}, 8'h01);
		check(8'(ndem), 8'(expc));
		pulse(1);
		check({7'h0, zpin}, 8'h01);
		check(8'(nzero), 8'(expc));
		rd_reg(mst_pkg::A_PRESC);
		check(v, {4'h0, ratio_exp});
		rd_reg(mst_pkg::A_STATUS);
		check(v, st_exp);
		wr_reg(mst_pkg::A_STATUS, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		hdem = 1'b0;
		hzero = 1'b0;
		scap = 1'b0;
		supd = 1'b0;
		v = 8'($urandom(32'hc8f3));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rd_reg(mst_pkg::A_PRESC);
		check(v, 8'h00);
		rd_reg(4'hc);
		check(v, 8'h00);
		// Autoswitched overflow with random capture contents
		r1 = 8'($urandom) & 8'hfe;
		r2 = 8'($urandom) & 8'hfe;
		wr_reg(mst_pkg::A_TIMER, 8'hf0);
		wr_reg(mst_pkg::A_ZCAP, r1);
		wr_reg(mst_pkg::A_PREV, r2);
		wr_reg(mst_pkg::A_CTRL_B, 8'h02);
		wr_reg(mst_pkg::A_PHASE, 8'h3c);
		wr_reg(mst_pkg::A_CTRL_C, 8'h09);
		wr_reg(mst_pkg::A_CTRL_A, 8'h0b);
		wr_reg(mst_pkg::A_PRESC, 8'h05);
		poll_ovf();
		check({7'h0, v[2]}, 8'h01);
		rd_reg(mst_pkg::A_TIMER);
		check({7'h0, v >= 8'h80}, 8'h01);
		rd_reg(mst_pkg::A_PRESC);
		check(v, 8'h01);
		rd_reg(mst_pkg::A_STATUS);
		check(v, 8'h01);
		check({7'h0, irq}, 8'h01);
		rd_reg(mst_pkg::A_ZCAP);
		check(v, r1 >> 1);
		rd_reg(mst_pkg::A_PREV);
		check(v, r2 >> 1);
		rd_reg(mst_pkg::A_DEMAG);
		check(v, 8'h80);
		check(8'(ncomm), 8'h00);
		wr_reg(mst_pkg::A_STATUS, 8'h00);
		#1;
		check({7'h0, irq}, 8'h00);
		// Three steps: no change, decrement, floor at zero
		step(4'h1, 8'h00);
		rd_reg(mst_pkg::A_PREV);
		check(v, r1 >> 1);
		rd_reg(mst_pkg::A_TIMER);
		check({7'h0, v < 8'h10}, 8'h01);
		step(4'h0, 8'h02);
		// Third step in sensor mode: demag pin toggles on commutation
		wr_reg(mst_pkg::A_CTRL_A, 8'h8b);
		step(4'h0, 8'h00);
		check({7'h0, dpin}, 8'h01);
		// Speed mode debug toggles from random capture and update pulses
		wr_reg(mst_pkg::A_CTRL_A, 8'h11);
		repeat (2) @(posedge mclk);
		#1;
		d0 = dpin;
		z0 = zpin;
		nc = 0;
		nu = 0;
		repeat (40) begin
			@(posedge mclk);
			v = 8'($urandom);
			scap <= v[0];
			supd <= v[1];
			nc += v[0];
			nu += v[1];
		end
		@(posedge mclk);
		scap <= 1'b0;
		supd <= 1'b0;
		#1;
		check({7'h0, dpin}, {7'h0, d0 ^ nc[0]});
		check({7'h0, zpin}, {7'h0, z0 ^ nu[0]});
		// Clock enable low: capture pulses must not toggle the pin
		@(posedge mclk);
		ce <= 1'b0;
		scap <= 1'b1;
		repeat (5) @(posedge mclk);
		ce <= 1'b1;
		scap <= 1'b0;
		@(posedge mclk);
		#1;
		check({7'h0, dpin}, {7'h0, d0 ^ nc[0]});
		// Direct access: phase write applies the step config at once
		wr_reg(mst_pkg::A_CTRL_A, 8'h51);
		wr_reg(mst_pkg::A_PHASE, 8'ha5);
		#1;
		check(cfg.ph, 8'ha5);
		check({4'h0, cfg.cb}, 8'h02);
		// Autoswitch off: simulated demag and zero, overflow keeps ratio
		wr_reg(mst_pkg::A_CTRL_A, 8'h01);
		wr_reg(mst_pkg::A_CTRL_B, 8'h04);
		wr_reg(mst_pkg::A_CTRL_C, 8'h0b);
		wr_reg(mst_pkg::A_COMP, 8'h00);
		wr_reg(mst_pkg::A_DEMAG, 8'h00);
		wr_reg(mst_pkg::A_ZCAP, 8'h00);
		@(posedge mclk);
		#1;
		check(8'(ndem), 8'h04);
		check(8'(nzero), 8'h04);
		poll_ovf();
		check({7'h0, v[2]}, 8'h01);
		rd_reg(mst_pkg::A_PRESC);
		check(v, 8'h00);
		rd_reg(mst_pkg::A_STATUS);
		check(v, 8'h00);
		// Saturated ratio overflow
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		wr_reg(mst_pkg::A_PRESC, 8'h0f);
		wr_reg(mst_pkg::A_TIMER, 8'hff);
		wr_reg(mst_pkg::A_CTRL_A, 8'h0b);
		poll_ovf();
		check({7'h0, v[2]}, 8'h01);
		rd_reg(mst_pkg::A_TIMER);
		check(v, 8'h00);
		rd_reg(mst_pkg::A_PRESC);
		check(v, 8'h0f);
		rd_reg(mst_pkg::A_STATUS);
		check(v, 8'h00);
		check({7'h0, irq}, 8'h00);
		close_out();
	end
endmodule // mst_timer_tb
`default_nettype wire
